// file: core/ssq_sequencer.sv
// switch scan sequencer: continuous and standard polling scans
`timescale 1ns/1ps
`include "ssq_map.svh"
module ssq_sequencer import ssq_pkg::*; #(
	parameter int unsigned STARTUP_CYC = `SSQ_STARTUP_CYC,
	parameter int unsigned ACT_BASE_CYC = `SSQ_ACT_MIN_CYC,
	parameter int unsigned POLL_BASE_CYC = `SSQ_POLL_MIN_CYC
) (
	// clocks and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic link_clk,
	// configuration
	input wire logic trigger,
	input wire logic poll_mode,
	input wire logic [23:0] input_enable,
	input wire logic [23:0] int_enable,
	input wire logic [23:0] adc_mode,
	input wire logic [35:0] wetting_current_cfg_lo,
	input wire logic [35:0] wetting_current_cfg_hi,
	input wire logic [2:0] active_window_select,
	input wire logic [3:0] poll_time_select,
	input wire logic [9:0] adc_threshold,
	// analog front end
	input wire logic [23:0] comp_above,
	output logic adc_start,
	input wire logic adc_done,
	input wire logic [9:0] adc_data,
	output logic [23:0] wetting_enable,
	output logic [71:0] wetting_level,
	// status
	output logic [23:0] comp_status,
	output logic [5:0] adc_switch_status_lo,
	output logic [5:0] adc_switch_status_hi,
	output logic [119:0] analog_values,
	output logic switch_change_flag,
	output logic int_n,
	// link side
	input wire logic int_stat_read,
	output logic spi_ssc_flag
);
	localparam int unsigned DWELL_CYC = `SSQ_DWELL_CYC;

	ssq_state_type state_ff, nxt_state;
	logic [4:0] ch_ff, nxt_ch;
	logic [31:0] cnt_ff, nxt_cnt;
	logic [31:0] per_ff;
	logic [23:0] comp_s1_ff, comp_s2_ff;
	logic trig_d_ff, first_ff, pend_ff, ssc_ff, int_n_ff, adc_start_ff;
	logic [23:0] comp_st_ff, wet_en_ff;
	logic [11:0] adc_st_ff;
	logic [119:0] ana_ff;
	logic [71:0] wet_lvl_ff, nxt_wet_lvl;
	logic [23:0] nxt_wet_en;
	logic rd_tgl_ff, rd_s1_ff, rd_s2_ff, rd_s3_ff;
	logic lk_s1_ff, lk_s2_ff;
	logic [2:0] act_sel;
	logic [3:0] poll_sel;
	logic [31:0] win_cyc, per_cyc;
	logic trig_rise, ch_en, is_adc, last_ch, sample_done, sample_fire;
	logic above_now, ref_bit, chg_now, cyc_end, cycle_start, rd_clr, ssc_set;
	logic [71:0] wc_all;

	// window from select field in polling mode, fixed dwell otherwise; period from select field
	assign act_sel = (active_window_select > `SSQ_ACT_SEL_MAX) ? `SSQ_ACT_SEL_MAX : active_window_select;
	assign poll_sel = (poll_time_select > `SSQ_POLL_SEL_MAX) ? `SSQ_POLL_SEL_MAX : poll_time_select;
	assign win_cyc = poll_mode ? (ACT_BASE_CYC << act_sel) : DWELL_CYC;
	assign per_cyc = POLL_BASE_CYC << poll_sel;

	assign trig_rise = trigger && !trig_d_ff;
	assign ch_en = input_enable[ch_ff];
	assign is_adc = adc_mode[ch_ff] && (ch_ff <= `SSQ_ADC_LAST_CH);
	assign last_ch = (ch_ff == `SSQ_LAST_CH);
	assign sample_done = is_adc ? adc_done : 1'b1;
	assign sample_fire = (state_ff == SSQ_SAMPLE) && sample_done && trigger;
	assign above_now = is_adc ? (adc_data >= adc_threshold) : comp_s2_ff[ch_ff];
	assign ref_bit = is_adc ? adc_st_ff[ch_ff[3:0]] : comp_st_ff[ch_ff];
	assign chg_now = sample_fire && !first_ff && (above_now != ref_bit) && int_enable[ch_ff];
	assign cyc_end = trigger && (nxt_state == SSQ_WAIT) && (state_ff != SSQ_WAIT);
	assign cycle_start = (nxt_state == SSQ_DWELL) && ((state_ff == SSQ_STARTUP) || (state_ff == SSQ_WAIT));
	// first scan always, later only on change
	assign ssc_set = cyc_end && (first_ff || pend_ff || chg_now);
	assign rd_clr = rd_s2_ff ^ rd_s3_ff;
	assign wc_all = {wetting_current_cfg_hi, wetting_current_cfg_lo};

	// scan sequence
	always_comb begin
		nxt_state = state_ff;
		nxt_ch = ch_ff;
		nxt_cnt = cnt_ff;
		unique case (state_ff)
			SSQ_IDLE: begin
				if (trig_rise) begin
					nxt_state = SSQ_STARTUP;
					nxt_cnt = 32'h0;
				end
			end
			SSQ_STARTUP: begin
				if (cnt_ff >= STARTUP_CYC - 1) begin
					nxt_state = SSQ_DWELL;
					nxt_ch = `SSQ_FIRST_CH;
					nxt_cnt = 32'h0;
				end else begin
					nxt_cnt = cnt_ff + 32'h1;
				end
			end
			SSQ_DWELL: begin
				if (!ch_en) begin
					nxt_cnt = 32'h0;
					if (last_ch) begin
						nxt_state = SSQ_WAIT;
					end else begin
						nxt_ch = ch_ff + 5'h1;
					end
				end else if (cnt_ff >= win_cyc - 1) begin
					nxt_state = SSQ_SAMPLE;
				end else begin
					nxt_cnt = cnt_ff + 32'h1;
				end
			end
			SSQ_SAMPLE: begin
				if (sample_done) begin
					nxt_cnt = 32'h0;
					if (last_ch) begin
						nxt_state = SSQ_WAIT;
					end else begin
						nxt_state = SSQ_DWELL;
						nxt_ch = ch_ff + 5'h1;
					end
				end
			end
			SSQ_WAIT: begin
				if (per_ff >= per_cyc - 1) begin
					nxt_state = SSQ_DWELL;
					nxt_ch = `SSQ_FIRST_CH;
					nxt_cnt = 32'h0;
				end
			end
			default: begin
				nxt_state = SSQ_IDLE;
			end
		endcase
		if (!trigger) begin
			nxt_state = SSQ_IDLE;
			nxt_cnt = 32'h0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= SSQ_IDLE;
			ch_ff <= `SSQ_FIRST_CH;
			cnt_ff <= 32'h0;
			trig_d_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			ch_ff <= nxt_ch;
			cnt_ff <= nxt_cnt;
			trig_d_ff <= trigger;
		end
	end

	// period timer
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			per_ff <= 32'h0;
		end else if (cycle_start) begin
			per_ff <= 32'h0;
		end else if (per_ff != 32'hFFFFFFFF) begin
			per_ff <= per_ff + 32'h1;
		end
	end

	// comparator pins synchroniser
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			comp_s1_ff <= 24'h0;
			comp_s2_ff <= 24'h0;
		end else begin
			comp_s1_ff <= comp_above;
			comp_s2_ff <= comp_s1_ff;
		end
	end

	// adc conversion request
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			adc_start_ff <= 1'b0;
		end else begin
			adc_start_ff <= (nxt_state == SSQ_SAMPLE) && (state_ff != SSQ_SAMPLE) && is_adc;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			comp_st_ff <= 24'h0;
			adc_st_ff <= 12'h0;
			ana_ff <= 120'h0;
		end else if (sample_fire) begin
			if (is_adc) begin
				adc_st_ff[ch_ff[3:0]] <= above_now;
				ana_ff[ch_ff[3:0] * `SSQ_ADC_W +: `SSQ_ADC_W] <= adc_data;
			end else begin
				comp_st_ff[ch_ff] <= above_now;
			end
		end
	end

	// first scan and pending change
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			first_ff <= 1'b0;
			pend_ff <= 1'b0;
		end else begin
			if (trig_rise) begin
				first_ff <= 1'b1;
			end else if (cyc_end) begin
				first_ff <= 1'b0;
			end
			if (cycle_start) begin
				pend_ff <= 1'b0;
			end else if (chg_now) begin
				pend_ff <= 1'b1;
			end
		end
	end

	// interrupt flag and pin, set wins over clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ssc_ff <= 1'b0;
			int_n_ff <= 1'b1;
		end else begin
			ssc_ff <= ssc_set || (ssc_ff && !rd_clr);
			int_n_ff <= !(ssc_set || (ssc_ff && !rd_clr));
		end
	end

	always_comb begin
		nxt_wet_en = 24'h0;
		nxt_wet_lvl = 72'h0;
		for (int i = 0; i < `SSQ_NCH; i++) begin
			// 0 mA input gets no current
			if (input_enable[i] && (wc_all[i * `SSQ_WC_W +: `SSQ_WC_W] != `SSQ_WC_OFF)
				&& (wc_all[i * `SSQ_WC_W +: `SSQ_WC_W] <= `SSQ_WC_MAX)) begin
				if (poll_mode) begin
					nxt_wet_en[i] = ((nxt_state == SSQ_DWELL) || (nxt_state == SSQ_SAMPLE))
						&& (nxt_ch == i[4:0]);
				end else begin
					nxt_wet_en[i] = (nxt_state != SSQ_IDLE) && (nxt_state != SSQ_STARTUP);
				end
			end
			if (nxt_wet_en[i]) begin
				nxt_wet_lvl[i * `SSQ_WC_W +: `SSQ_WC_W] = wc_all[i * `SSQ_WC_W +: `SSQ_WC_W];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wet_en_ff <= 24'h0;
			wet_lvl_ff <= 72'h0;
		end else begin
			wet_en_ff <= nxt_wet_en;
			wet_lvl_ff <= nxt_wet_lvl;
		end
	end

	// status read toggle on link clock
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_tgl_ff <= 1'b0;
		end else if (int_stat_read) begin
			rd_tgl_ff <= !rd_tgl_ff;
		end
	end

	// read event into core clock
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_s1_ff <= 1'b0;
			rd_s2_ff <= 1'b0;
			rd_s3_ff <= 1'b0;
		end else begin
			rd_s1_ff <= rd_tgl_ff;
			rd_s2_ff <= rd_s1_ff;
			rd_s3_ff <= rd_s2_ff;
		end
	end

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			lk_s1_ff <= 1'b0;
			lk_s2_ff <= 1'b0;
		end else begin
			lk_s1_ff <= ssc_ff;
			lk_s2_ff <= lk_s1_ff;
		end
	end

	assign adc_start = adc_start_ff;
	assign wetting_enable = wet_en_ff;
	assign wetting_level = wet_lvl_ff;
	assign comp_status = comp_st_ff;
	assign adc_switch_status_lo = adc_st_ff[5:0];
	assign adc_switch_status_hi = adc_st_ff[11:6];
	assign analog_values = ana_ff;
	assign switch_change_flag = ssc_ff;
	assign int_n = int_n_ff;
	assign spi_ssc_flag = lk_s2_ff;

	// checks
	AST_INT_PIN: assert property (@(posedge mclk) disable iff (!rst_n) int_n == !switch_change_flag)
		else $error("interrupt pin disagrees with flag");
	AST_ORDER: assert property (@(posedge mclk) disable iff (!rst_n)
		(sample_fire && !last_ch) |=> (ch_ff == $past(ch_ff) + 5'h1))
		else $error("channel order broken");
	AST_STARTUP: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_ff == SSQ_DWELL && $past(state_ff) == SSQ_STARTUP) |-> $past(cnt_ff) == STARTUP_CYC - 1)
		else $error("startup delay wrong");
	AST_ONE_WET: assert property (@(posedge mclk) disable iff (!rst_n)
		(poll_mode && $past(poll_mode)) |-> $onehot0(wetting_enable))
		else $error("more than one channel wetted in polling");
	AST_WAIT_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
		(poll_mode && $past(poll_mode) && state_ff == SSQ_WAIT && $past(state_ff) == SSQ_WAIT) |-> wetting_enable == 24'h0)
		else $error("wetting on outside window");
	AST_FIRST_INT: assert property (@(posedge mclk) disable iff (!rst_n)
		(cyc_end && first_ff) |=> switch_change_flag && !int_n)
		else $error("no interrupt after first scan");
	AST_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
		(rd_clr && !ssc_set) |=> !switch_change_flag ##0 int_n)
		else $error("read did not clear interrupt");
	AST_NO_SPUR: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(switch_change_flag) |-> $past(cyc_end) && ($past(first_ff) || $past(pend_ff) || $past(chg_now)))
		else $error("interrupt without cause");
	AST_REF: assert property (@(posedge mclk) disable iff (!rst_n)
		(sample_fire && !is_adc) |=> comp_status[$past(ch_ff)] == $past(above_now))
		else $error("reference not updated");
	AST_WINDOW: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_ff == SSQ_SAMPLE && $past(state_ff) == SSQ_DWELL) |-> $past(cnt_ff) == win_cyc - 1)
		else $error("active window length wrong");
	COV_FIRST: cover property (@(posedge mclk) disable iff (!rst_n) cyc_end && first_ff);
	COV_CHANGE: cover property (@(posedge mclk) disable iff (!rst_n) ssc_set && !first_ff);
	COV_ADC: cover property (@(posedge mclk) disable iff (!rst_n) sample_fire && is_adc);
endmodule : ssq_sequencer

// file: core/ssq_map.svh
// constants of the switch scan sequencer
// Function
// - continuous mode keeps enabled inputs wetted, samples channel 0 up to 23
// - continuous mode flags enabled-interrupt status changes on any enabled input
// - each input picks 0, 1, 2, 5, 10 or 15 mA from two config words
// - inputs 0 to 11 are judged by comparator or ADC per their mode bit, inputs 12 to 23 by comparator only
// - after trigger set, wait the startup delay, then switch wetting on
// - each result is stored as reference; ADC values go to twelve registers
// - first finished scan drives interrupt low and sets switch change flag
// - interrupt always after first scan, later only on a status change
// - host reading interrupt status clears it and releases the pin
// - each input sampled once per programmable poll period
// - 0 mA inputs get no current but are still compared
// - polling mode wets one channel at a time, channel 0 up to 23
// - polling mode change on interrupt-enabled channel raises interrupt and flag
// - polling starts on trigger; standard scheme here, matrix left out
// - polling active window 64 us to 2048 us by select field
// - input sampled by comparator or ADC at end of active window
// - polling scan repeats every 2 ms to 4096 ms by select field
// - polling mode wets only during active window, off otherwise
// - changes between active windows are never seen
`ifndef SSQ_MAP_SVH
`define SSQ_MAP_SVH
`define SSQ_CLK_MHZ 200
`define SSQ_STARTUP_US 200
`define SSQ_STARTUP_CYC (`SSQ_STARTUP_US * `SSQ_CLK_MHZ)
`define SSQ_ACT_MIN_US 64
`define SSQ_ACT_MIN_CYC (`SSQ_ACT_MIN_US * `SSQ_CLK_MHZ)
`define SSQ_POLL_MIN_MS 2
`define SSQ_POLL_MIN_CYC (`SSQ_POLL_MIN_MS * 1000 * `SSQ_CLK_MHZ)
`define SSQ_DWELL_NS 200
`define SSQ_DWELL_CYC (`SSQ_DWELL_NS * `SSQ_CLK_MHZ / 1000)
`define SSQ_ACT_SEL_MAX 3'h5
`define SSQ_POLL_SEL_MAX 4'hB
`define SSQ_WC_MAX 3'h5
`define SSQ_WC_OFF 3'h0
`define SSQ_NCH 24
`define SSQ_NADC 12
`define SSQ_WC_W 3
`define SSQ_ADC_W 10
`define SSQ_FIRST_CH 5'h00
`define SSQ_LAST_CH 5'h17
`define SSQ_ADC_LAST_CH 5'h0B
`endif

// file: core/ssq_pkg.sv
// types of the switch scan sequencer
package ssq_pkg;
	typedef enum logic [2:0] {
		SSQ_IDLE = 3'h0,
		SSQ_STARTUP = 3'h1,
		SSQ_DWELL = 3'h3,
		SSQ_SAMPLE = 3'h2,
		SSQ_WAIT = 3'h6
	} ssq_state_type;
endpackage : ssq_pkg

// file: verification/ssq_host_model.sv
// host model: acknowledges the switch interrupt over the link
`timescale 1ns/1ps
module ssq_host_model (
	// link side
	input wire logic link_clk,
	input wire logic rst_n,
	input wire logic int_n,
	input wire logic ack_en,
	output logic int_stat_read
);
	logic [1:0] int_sync_ff;
	logic [3:0] hold_ff;
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n)
			int_sync_ff <= 2'h3;
		else
			int_sync_ff <= {int_sync_ff[0], int_n};
	end
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_stat_read <= 1'b0;
			hold_ff <= 4'h0;
		end else begin
			int_stat_read <= 1'b0;
			if (hold_ff != 4'h0)
				hold_ff <= hold_ff - 4'h1;
			else if (ack_en && !int_sync_ff[1]) begin
				int_stat_read <= 1'b1;
				hold_ff <= 4'hF;
			end
		end
	end
endmodule : ssq_host_model

// file: verification/switch_scan_sequencer_test.sv
// testbench of the switch scan sequencer
`timescale 1ns/1ps
module switch_scan_sequencer_test;
	logic mclk = 0, link_clk = 0, rst_n = 0, trigger = 0, poll_mode = 0, adc_done = 0, ack_en = 0;
	logic [23:0] input_enable = 24'h000029, int_enable = 24'hFFFFFF, adc_mode = 24'h000008;
	logic [23:0] comp_above = 24'h000001;
	logic [35:0] wc_lo = 36'h000000405, wc_hi = 36'h000000000;
	logic [2:0] act_sel = 3'h1;
	logic [3:0] poll_sel = 4'h0;
	logic [9:0] adc_data = 10'h2A5;
	logic adc_start, switch_change_flag, int_n, int_stat_read, spi_ssc_flag;
	logic [23:0] wetting_enable, comp_status;
	logic [71:0] wetting_level;
	logic [5:0] st_lo, st_hi;
	logic [119:0] analog_values;
	int n_errors = 0, n_compared = 0, cyc = 0;
	always #2.5 mclk = ~mclk;
	initial #3 forever #16 link_clk = ~link_clk;
	always @(negedge mclk) adc_done <= adc_start;
	ssq_sequencer #(.STARTUP_CYC(20), .ACT_BASE_CYC(50), .POLL_BASE_CYC(4000)) u_ssq_sequencer (
		.mclk(mclk), .rst_n(rst_n), .link_clk(link_clk), .trigger(trigger), .poll_mode(poll_mode),
		.input_enable(input_enable), .int_enable(int_enable), .adc_mode(adc_mode),
		.wetting_current_cfg_lo(wc_lo), .wetting_current_cfg_hi(wc_hi), .active_window_select(act_sel),
		.poll_time_select(poll_sel), .adc_threshold(10'h200), .comp_above(comp_above), .adc_start(adc_start),
		.adc_done(adc_done), .adc_data(adc_data), .wetting_enable(wetting_enable), .wetting_level(wetting_level),
		.comp_status(comp_status), .adc_switch_status_lo(st_lo), .adc_switch_status_hi(st_hi),
		.analog_values(analog_values), .switch_change_flag(switch_change_flag), .int_n(int_n),
		.int_stat_read(int_stat_read), .spi_ssc_flag(spi_ssc_flag));
	ssq_host_model u_ssq_host_model (.link_clk(link_clk), .rst_n(rst_n), .int_n(int_n), .ack_en(ack_en),
		.int_stat_read(int_stat_read));
	task automatic chk(string nm, logic [71:0] seen, logic [71:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wait_int(logic lvl);
		for (int i = 0; i < 20000 && int_n !== lvl; i++) @(negedge mclk);
		chk("int_n", int_n, lvl);
	endtask : wait_int
	task automatic wait_wet();
		for (int i = 0; i < 400 && wetting_enable === 24'h0; i++) @(negedge mclk);
	endtask : wait_wet
	task automatic ack();
		repeat (3) @(negedge link_clk);
		chk("spi flag set", spi_ssc_flag, 1'b1);
		chk("change flag set", switch_change_flag, 1'b1);
		@(negedge mclk) ack_en = 1'b1;
		wait_int(1'b1);
		@(negedge mclk) ack_en = 1'b0;
		chk("change flag cleared", switch_change_flag, 1'b0);
		repeat (3) @(negedge link_clk);
		chk("spi flag cleared", spi_ssc_flag, 1'b0);
	endtask : ack
	task automatic t_cont();
		int lows;
		@(negedge mclk) trigger = 1'b1;
		repeat (10) @(negedge mclk);
		chk("startup wetting off", wetting_enable, 24'h0);
		repeat (30) @(negedge mclk);
		chk("continuous wetting", wetting_enable, 24'h000009);
		chk("wetting levels", wetting_level, 72'h405);
		wait_int(1'b0);
		chk("comparator status", comp_status & 24'h000021, 24'h000001);
		chk("0 mA input compared", comp_status[5], 1'b0);
		chk("adc status", st_lo[3], 1'b1);
		chk("adc status high", st_hi, 6'h00);
		chk("analog value", analog_values[39:30], 10'h2A5);
		ack();
		lows = 0;
		repeat (9000) @(negedge mclk) lows += (int_n !== 1'b1);
		chk("no change no interrupt", lows, 0);
		comp_above[5] = 1'b1;
		adc_data = 10'h100;
		wait_int(1'b0);
		chk("reference updated", comp_status[5], 1'b1);
		chk("adc reference updated", st_lo[3], 1'b0);
		chk("analog value updated", analog_values[39:30], 10'h100);
		ack();
		$display("test continuous done");
	endtask : t_cont
	task automatic t_poll();
		int n;
		@(negedge mclk) trigger = 1'b0;
		repeat (3) @(negedge mclk);
		chk("abort wetting off", wetting_enable, 24'h0);
		poll_mode = 1'b1;
		trigger = 1'b1;
		wait_wet();
		chk("first window", wetting_enable, 24'h000001);
		n = 0;
		while (wetting_enable[0] === 1'b1 && n < 400) @(negedge mclk) n++;
		chk("window length", n >= 100 && n <= 102, 1'b1);
		wait_wet();
		chk("second window", wetting_enable, 24'h000008);
		wait_int(1'b0);
		chk("wetting off after scan", wetting_enable, 24'h0);
		ack();
		comp_above[0] = 1'b0;
		repeat (20) @(negedge mclk);
		comp_above[0] = 1'b1;
		n = 0;
		repeat (9000) @(negedge mclk) n += (int_n !== 1'b1);
		chk("blind between windows", n, 0);
		chk("status untouched", comp_status[0], 1'b1);
		comp_above[0] = 1'b0;
		wait_int(1'b0);
		chk("polled change stored", comp_status[0], 1'b0);
		ack();
		$display("test polling done");
	endtask : t_poll
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 80000) begin
			n_errors++;
			close_out();
		end
	end
	initial begin
		repeat (20) @(negedge mclk);
		rst_n = 1'b1;
		repeat (2) @(negedge mclk);
		t_cont();
		t_poll();
		close_out();
	end
endmodule : switch_scan_sequencer_test
